// ==== rtl/rsf_pkg.sv ====
/*
  rsf_pkg: shared constants and carrier types of the shortened rs encoder.
  assumes: included before every design file; nothing is imported.
*/
package rsf_pkg;
  // ----------------------------------------------------------------
  // code shape
  // ----------------------------------------------------------------
  localparam int SYM_W = 8;             // bits per symbol
  localparam int CODE_N = 255;          // full codeword length
  localparam int PAR_N = 6;             // check symbols per codeword
  localparam int MSG_MAX = CODE_N - PAR_N; // 249 message symbols in a full block
  localparam int CNT_W = 8;             // width of symbol counters
  localparam logic [2:0] PAR_LAST = 3'h5; // index of the final check symbol

  // ----------------------------------------------------------------
  // field arithmetic: z^8 = z^4+z^3+z^2+1, bit 7 is z^7
  // ----------------------------------------------------------------
  localparam logic [7:0] PRIM_LOW = 8'h1D;

  // generator g(x) = x^6 + 126x^5 + 4x^4 + 158x^3 + 58x^2 + 49x + 117
  localparam logic [7:0] G5 = 8'h7E;
  localparam logic [7:0] G4 = 8'h04;
  localparam logic [7:0] G3 = 8'h9E;
  localparam logic [7:0] G2 = 8'h3A;
  localparam logic [7:0] G1 = 8'h31;
  localparam logic [7:0] G0 = 8'h75;

  localparam logic [7:0] SYM_ZERO = 8'h00;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [7:0] CNT_ONE = 8'h01;

  // ----------------------------------------------------------------
  // carriers and states
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] sym;   // symbol value
    logic last;        // final symbol of the block
  } rsf_sym_s;

  typedef struct packed {
    logic [7:0] sym;   // symbol value
    logic last;        // final symbol of the codeword
    logic check;       // symbol is a check symbol
  } rsf_out_s;

  typedef enum logic [1:0] {
    RSF_MSG = 2'b00,   // taking message symbols
    RSF_PAR = 2'b01    // emitting check symbols
  } rsf_state_e;
endpackage

// ==== rtl/rsf_gfmul.sv ====
/*
  rsf_gfmul: combinational multiply in the 256-element field.
  assumes: operands use the bit order of the package, bit 7 as z^7.
*/
`timescale 1ns/10ps
module rsf_gfmul (
  // operands
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  // product
  output logic [7:0] p
);
  // ----------------------------------------------------------------
  // shift-and-add with reduction by the primitive polynomial
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] acc;
    logic [7:0] sh;
    acc = rsf_pkg::SYM_ZERO;
    sh = a;
    for (int i = 0; i < 8; i++) begin
      // add the shifted operand where b has a one
      if (b[i]) begin
        acc = acc ^ sh;
      end
      // multiply by z and fold the overflow back in
      sh = {sh[6:0], 1'b0} ^ (sh[7] ? rsf_pkg::PRIM_LOW : rsf_pkg::SYM_ZERO);
    end
    p = acc;
  end
endmodule

// ==== rtl/rsf_encoder.sv ====
/*
  rsf_encoder: systematic shortened reed-solomon encoder, six check symbols.
  assumes: source and sink share clk; a block ends on its last flag or
  after the full message length, whichever comes first.
*/
`timescale 1ns/10ps
// Functional notes
// - systematic code, message passed, checks appended
// - arithmetic in field from given primitive
// - bit seven holds z^7 coefficient
// - checks are remainder by degree-6 generator
// - shortening equals leading zeros, then dropped
// - short final block shortened, never padded
// - shortened code keeps full minimum distance
module rsf_encoder (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // message input
  input wire logic in_valid,
  input rsf_pkg::rsf_sym_s in_data,
  output logic in_ready,
  // codeword output
  output logic out_valid,
  output rsf_pkg::rsf_out_s out_data,
  input wire logic out_ready
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  rsf_pkg::rsf_state_e state_q, state_d;   // message or check phase
  logic [7:0] rem_q [6];                   // remainder, rem_q[5] highest degree
  logic [7:0] rem_d [6];
  logic [7:0] cnt_q, cnt_d;                // message symbols of this block
  logic [2:0] pidx_q, pidx_d;              // check symbol being emitted
  logic out_valid_q, out_valid_d;          // output register holds a symbol
  rsf_pkg::rsf_out_s out_q, out_d;
  logic [7:0] fb;                          // feedback symbol
  logic [7:0] prod [6];                    // feedback times generator terms
  logic take;                              // message symbol accepted this cycle
  logic slot_free;                         // output register can be loaded
  logic blk_end;                           // accepted symbol closes the block
  logic rem_zero;                          // remainder all zero, read by checks only

  localparam logic [7:0] GEN [6] = '{rsf_pkg::G0, rsf_pkg::G1, rsf_pkg::G2,
                                     rsf_pkg::G3, rsf_pkg::G4, rsf_pkg::G5};
  // unit symbol: fed into a clear remainder it leaves the generator itself
  localparam logic [7:0] SYM_UNIT = 8'h01;

  // ----------------------------------------------------------------
  // field multipliers, one per generator coefficient below the leading x^6
  // ----------------------------------------------------------------
  // field multiply
  for (genvar g = 0; g < 6; g++) begin : g_mul
    rsf_gfmul u_mul (
      .a(fb),
      .b(GEN[g]),
      .p(prod[g])
    );
  end

  // ----------------------------------------------------------------
  // handshake terms
  // ----------------------------------------------------------------
  // output stage is one register; it frees when the sink takes it
  assign slot_free = !out_valid_q || out_ready;
  assign in_ready = (state_q == rsf_pkg::RSF_MSG) && slot_free;
  assign take = in_valid && in_ready;
  assign blk_end = in_data.last || (cnt_q == 8'(rsf_pkg::MSG_MAX - 1));
  assign fb = in_data.sym ^ rem_q[5];
  // names a clean block start for the assertions below
  assign rem_zero = ~|{rem_q[0], rem_q[1], rem_q[2], rem_q[3], rem_q[4], rem_q[5]};

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  // everything holds by default; the output register empties when taken
  // a stall freezes both phases, so no symbol is ever dropped or doubled
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    pidx_d = pidx_q;
    out_valid_d = out_valid_q && !out_ready;
    out_d = out_q;
    for (int i = 0; i < 6; i++) begin
      rem_d[i] = rem_q[i];
    end
    unique case (state_q)
      rsf_pkg::RSF_MSG: begin
        if (take) begin
          out_valid_d = 1'b1;
          out_d.sym = in_data.sym;
          out_d.last = 1'b0;
          out_d.check = 1'b0;
          rem_d[0] = prod[0];
          for (int i = 1; i < 6; i++) begin
            rem_d[i] = rem_q[i-1] ^ prod[i];
          end
          cnt_d = cnt_q + rsf_pkg::CNT_ONE;
          // leading zeros leave remainder untouched, so skipped
          if (blk_end) begin
            state_d = rsf_pkg::RSF_PAR;
            pidx_d = 3'h0;
          end
        end
      end
      rsf_pkg::RSF_PAR: begin
        if (slot_free) begin
          out_valid_d = 1'b1;
          out_d.sym = rem_q[5];
          out_d.check = 1'b1;
          out_d.last = (pidx_q == rsf_pkg::PAR_LAST);
          for (int i = 5; i > 0; i--) begin
            rem_d[i] = rem_q[i-1];
          end
          rem_d[0] = rsf_pkg::SYM_ZERO;
          pidx_d = pidx_q + 3'h1;
          if (pidx_q == rsf_pkg::PAR_LAST) begin
            state_d = rsf_pkg::RSF_MSG;
            cnt_d = rsf_pkg::CNT_ZERO;
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // synchronous reset returns to a clean message phase with no output
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= rsf_pkg::RSF_MSG;
      cnt_q <= rsf_pkg::CNT_ZERO;
      pidx_q <= 3'h0;
      out_valid_q <= 1'b0;
      out_q <= '0;
      for (int i = 0; i < 6; i++) begin
        rem_q[i] <= rsf_pkg::SYM_ZERO;
      end
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      pidx_q <= pidx_d;
      out_valid_q <= out_valid_d;
      out_q <= out_d;
      for (int i = 0; i < 6; i++) begin
        rem_q[i] <= rem_d[i];
      end
    end
  end

  // both outputs come straight from the output register
  assign out_valid = out_valid_q;
  assign out_data = out_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // shifting out leaves zeros, so the block after always starts clean
  sequence par_done_s;
    state_q == rsf_pkg::RSF_PAR && slot_free && pidx_q == rsf_pkg::PAR_LAST;
  endsequence

  // one check symbol leaves the remainder in this cycle
  sequence chk_emit_s;
    state_q == rsf_pkg::RSF_PAR && slot_free;
  endsequence

  // the accepted symbol closes its block
  sequence blk_close_s;
    take && blk_end;
  endsequence

  rem_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    par_done_s |=> (rem_zero && cnt_q == rsf_pkg::CNT_ZERO))
    else $error("remainder not clear at block start");
  six_checks_a: assert property (@(posedge clk) disable iff (!rst_n)
    blk_close_s |=> (state_q == rsf_pkg::RSF_PAR) [*6] ##0 (pidx_q <= rsf_pkg::PAR_LAST))
    else $error("check phase shorter than six");
  pass_through_a: assert property (@(posedge clk) disable iff (!rst_n)
    take |=> (out_valid && out_data.sym == $past(in_data.sym) && !out_data.check))
    else $error("message symbol altered");
  no_take_par_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == rsf_pkg::RSF_PAR |-> !in_ready)
    else $error("input taken during checks");
  max_len_a: assert property (@(posedge clk) disable iff (!rst_n)
    cnt_q <= 8'(rsf_pkg::MSG_MAX))
    else $error("block longer than full message");
  last_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    (out_valid && out_data.last) |-> out_data.check)
    else $error("last flag on non-check symbol");
  hold_out_a: assert property (@(posedge clk) disable iff (!rst_n)
    (out_valid && !out_ready) |=> (out_valid && $stable(out_data)))
    else $error("output changed while stalled");
  // a unit symbol into a clean remainder must leave the generator behind
  lfsr_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    (take && rem_zero && in_data.sym == SYM_UNIT) |=> (rem_q[5] == rsf_pkg::G5 &&
      rem_q[4] == rsf_pkg::G4 && rem_q[3] == rsf_pkg::G3 && rem_q[2] == rsf_pkg::G2 &&
      rem_q[1] == rsf_pkg::G1 && rem_q[0] == rsf_pkg::G0))
    else $error("remainder update wrong");
  // a block always begins from a clear remainder
  rem_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    (take && cnt_q == rsf_pkg::CNT_ZERO) |-> rem_zero)
    else $error("block started on stale remainder");
  // leading zeros change nothing, which is why shortening costs no logic
  zero_lead_a: assert property (@(posedge clk) disable iff (!rst_n)
    (take && rem_zero && in_data.sym == rsf_pkg::SYM_ZERO) |=> rem_zero)
    else $error("zero symbol disturbed clear remainder");
  end_to_par_a: assert property (@(posedge clk) disable iff (!rst_n)
    (take && in_data.last) |=> state_q == rsf_pkg::RSF_PAR)
    else $error("short block did not end on last");
  full_len_a: assert property (@(posedge clk) disable iff (!rst_n)
    (take && cnt_q == 8'(rsf_pkg::MSG_MAX - 1)) |=> state_q == rsf_pkg::RSF_PAR)
    else $error("full block did not end by count");
  check_emit_a: assert property (@(posedge clk) disable iff (!rst_n)
    chk_emit_s |=> (out_valid && out_data.check))
    else $error("check slot not marked as check");
endmodule

// ==== dv/rsf_sink.sv ====
/*
  rsf_sink: line coder stand-in that takes encoded symbols.
  assumes: shares clk with the encoder; the bench picks the stall mode.
*/
`timescale 1ns/10ps
module rsf_sink (
  // clock
  input wire logic clk,
  // stream from the encoder
  input wire logic out_valid,
  input rsf_pkg::rsf_out_s out_data,
  output logic out_ready,
  // stall control
  input wire logic slow
);
  rsf_pkg::rsf_out_s rx_q[$]; // taken symbols, oldest first
  logic ph_q = 1'b0;          // stall phase, flips each cycle
  initial out_ready = 1'b1;
  // ready handshake
  // ready moves at the falling edge only, away from the sampling edge
  always @(negedge clk) begin
    ph_q <= ~ph_q;
    out_ready <= slow ? ph_q : 1'b1;
  end
  // a symbol moves only where valid and ready meet
  always @(posedge clk) begin
    if (out_valid && out_ready) begin
      rx_q.push_back(out_data);
    end
  end
endmodule

// ==== dv/shortened_rs_fec_encoder_tb.sv ====
/*
  bench of the shortened rs encoder, with a hand-written field model.
  assumes: rsf_pkg and the design files are compiled first.
*/
`timescale 1ns/10ps
module shortened_rs_fec_encoder_tb;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic in_valid = 1'b0;
  rsf_pkg::rsf_sym_s in_data = '0;
  logic in_ready, out_valid, out_ready;
  rsf_pkg::rsf_out_s out_data;
  logic slow = 1'b0; // sink stalls every other cycle when high
  int err_total = 0;
  int tests_run = 0;
  rsf_encoder uut (.clk(clk), .rst_n(rst_n), .in_valid(in_valid), .in_data(in_data),
    .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready));
  rsf_sink u_sink (.clk(clk), .out_valid(out_valid), .out_data(out_data),
    .out_ready(out_ready), .slow(slow));
  initial forever #10 clk = ~clk;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // field product, shift and add
  function automatic logic [7:0] gmul(logic [7:0] a, logic [7:0] b);
    logic [7:0] p;
    p = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ a;
      a = {a[6:0], 1'b0} ^ (a[7] ? rsf_pkg::PRIM_LOW : 8'h00);
    end
    return p;
  endfunction
  // one division step, q[47:40] is the highest degree
  function automatic logic [47:0] rem_step(logic [47:0] q, logic [7:0] s);
    logic [7:0] f;
    f = s ^ q[47:40];
    return {q[39:0], 8'h00} ^ {gmul(f, rsf_pkg::G5), gmul(f, rsf_pkg::G4),
      gmul(f, rsf_pkg::G3), gmul(f, rsf_pkg::G2), gmul(f, rsf_pkg::G1), gmul(f, rsf_pkg::G0)};
  endfunction
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // called at a falling edge; holds the symbol until it is taken
  task automatic send_sym(input logic [7:0] s, input logic l);
    logic took;
    took = 1'b0;
    in_valid = 1'b1;
    in_data = '{sym: s, last: l};
    while (!took) begin
      #1;
      took = (in_ready === 1'b1);
      @(negedge clk);
    end
  endtask
  // sends k symbols, waits for the codeword, compares every symbol
  task automatic run_block(input int k, input bit use_last, input int base);
    logic [7:0] m[$];
    logic [47:0] r;
    logic [47:0] sr;
    logic [9:0] got;
    r = '0;
    sr = '0;
    for (int i = 0; i < k; i++) begin
      m.push_back(8'((i * 37 + base) % 256));
      r = rem_step(r, m[i]);
      send_sym(m[i], use_last && (i == k - 1));
    end
    in_valid = 1'b0;
    // the block has closed, so the input must be refused while checks drain
    check(10'(in_ready), 10'h000);
    for (int t = 0; t < 800 && u_sink.rx_q.size() < k + 6; t++) @(negedge clk);
    check(10'(in_ready), 10'h001);
    check(10'(u_sink.rx_q.size()), 10'(k + 6));
    // far decoder puts dropped zeros back first
    for (int i = k; i < rsf_pkg::MSG_MAX; i++) sr = rem_step(sr, 8'h00);
    for (int i = 0; i < k + 6; i++) begin
      got = u_sink.rx_q.pop_front();
      sr = rem_step(sr, got[9:2]);
      if (i < k) check(got, {m[i], 2'b00});
      else check(got, {r[8 * (k + 5 - i) +: 8], i == k + 5, 1'b1});
    end
    check(10'(|sr), 10'h000);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // a one-symbol block is shortened to seven symbols on the line
  // a unit symbol makes the checks the generator's own coefficients
  task automatic test_single();
    run_block(1, 1'b1, 1);
    $display("test single done");
  endtask
  // sink stalls while message and checks drain
  task automatic test_stall();
    slow = 1'b1;
    run_block(5, 1'b1, 3);
    slow = 1'b0;
    $display("test stall done");
  endtask
  // full block ends by count alone, then a short one finds a clear remainder
  // the short one leads with a zero symbol, as a shortened code would
  task automatic test_full();
    run_block(rsf_pkg::MSG_MAX, 1'b0, 5);
    run_block(2, 1'b1, 0);
    $display("test full done");
  endtask
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    test_single();
    test_stall();
    test_full();
    report_and_stop();
  end
  // the tests need well under a thousand cycles
  initial begin
    repeat (4000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
endmodule
